// ==== cdma_params.svh ====
// Register offsets, field positions and reset values of the codec slot DMA channel
`ifndef CDMA_PARAMS_SVH
`define CDMA_PARAMS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define CDMA_CTL_IDX        16'hfff4
`define CDMA_SLOT_HI_IDX    16'hfff5
`define CDMA_SLOT_LO_IDX    16'hfff6
`define CDMA_STAT_IDX       16'hfff0
`define CDMA_IDX_W          16

// ==========================================================================
// Control register fields
`define CDMA_CTL_EN_BIT     7
`define CDMA_CTL_WRAP_BIT   6
`define CDMA_CTL_DIR_BIT    3
`define CDMA_CTL_EP_MSB     2
`define CDMA_CTL_EP_LSB     0
`define CDMA_CTL_WR_MASK    8'hcf
`define CDMA_CTL_RST        8'h00

// ==========================================================================
// Slot select high register fields
`define CDMA_SLOT_HI_CNT_MSB 7
`define CDMA_SLOT_HI_CNT_LSB 6
`define CDMA_SLOT_HI_SEL_MSB 5
`define CDMA_SLOT_HI_SEL_LSB 0
`define CDMA_SLOT_HI_RST     8'h00
`define CDMA_SLOT_LO_RST     8'h00

// ==========================================================================
// Slot geometry
`define CDMA_NUM_SLOTS      14
`define CDMA_LAST_SLOT      4'hd

`endif

// ==== cdma_pkg.sv ====
// Types shared by the codec slot DMA channel modules
package cdma_pkg;

  typedef enum logic [2:0] {
    CDMA_IDLE,
    CDMA_SCAN,
    CDMA_SCAN_WAIT,
    CDMA_SRC,
    CDMA_DST
  } cdma_state_e;

  typedef struct packed {
    logic [7:0]  ctl;
    logic [13:0] slot_select;
    logic [1:0]  slot_byte_count;
    logic        waitreq;
    logic [31:0] rdata;
    cdma_state_e state;
    logic [3:0]  slot;
    logic [1:0]  byte_idx;
    logic [7:0]  data;
    logic        scan_go;
    logic        buf_req;
    logic        buf_we;
    logic        cpi_rd;
    logic        cpi_wr;
    logic        overrun;
  } cdma_top_s;

  typedef struct packed {
    logic       done;
    logic       found;
    logic [3:0] index;
  } cdma_scan_s;

endpackage

// ==== cdma_scan_if.sv ====
// Interface between the channel sequencer and the slot scanner
`timescale 1ns/1ps
`default_nettype none

interface cdma_scan_if;
  logic        go;
  logic [3:0]  start;
  logic [13:0] mask;
  logic        done;
  logic        found;
  logic [3:0]  index;

  modport seq  (output go, output start, output mask, input done, input found, input index);
  modport scan (input go, input start, input mask, output done, output found, output index);
endinterface

`default_nettype wire

// ==== cdma_slot_scan.sv ====
// Finds the lowest selected slot at or above a start slot, one cycle after go
`timescale 1ns/1ps
`default_nettype none

module cdma_slot_scan #(
  parameter int NUM_SLOTS = 14
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  cdma_scan_if.scan sif
);

  cdma_pkg::cdma_scan_s s_q;
  cdma_pkg::cdma_scan_s s_d;
  logic [NUM_SLOTS-1:0] hit;

  // ==========================================================================
  // Per-slot candidate: selected and not yet passed
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_hit
      assign hit[g] = sif.mask[g] && (4'(g) >= sif.start);
    end
  endgenerate

  // ==========================================================================
  // Lowest hit wins, so slots go out in ascending order
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (sif.go) begin
      s_d.done  = 1'b1;
      s_d.found = 1'b0;
      s_d.index = 4'h0;
      for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
        if (hit[i]) begin
          s_d.found = 1'b1;
          s_d.index = 4'(i);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sif.done  = s_q.done;
  assign sif.found = s_q.found;
  assign sif.index = s_q.index;

endmodule // cdma_slot_scan

`default_nettype wire

// ==== cdma_channel.sv ====
// Codec slot DMA channel: Avalon-MM registers and slot-by-slot byte sequencer
//
// Function
// - Move data only in codec time slots whose select bit is one.
// - Fourteen select bits: slots 0-7 low register, 8-13 high register bits 5:0.
// - High register bits 7:6 give one to four bytes per selected slot.
// - Control bit 3 one serves an IN endpoint, zero an OUT endpoint.
// - Control bits 2:0 hold the served endpoint number in plain binary.
// - Control bit 7 enables the channel; cleared, no transfers happen.
// - Control bit 6 enables wrap-around buffering, used only by buffer manager.
// - Control bits 5 and 4 are read-only zero.
`timescale 1ns/1ps
`default_nettype none
`include "cdma_params.svh"

module cdma_channel (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave, byte address
  input  wire logic [17:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  // Codec port interface side
  input  wire logic        cpi_frame_start,
  output var  logic        cpi_rd_req,
  output var  logic        cpi_wr_req,
  output var  logic [3:0]  cpi_slot,
  output var  logic [1:0]  cpi_byte,
  output var  logic [7:0]  cpi_wdata,
  input  wire logic [7:0]  cpi_rdata,
  input  wire logic        cpi_ack,
  // USB buffer manager side
  output var  logic        bufmgr_req,
  output var  logic        bufmgr_write,
  output var  logic [7:0]  bufmgr_wdata,
  input  wire logic [7:0]  bufmgr_rdata,
  input  wire logic        bufmgr_ack,
  output var  logic [2:0]  endpoint_number,
  output var  logic        endpoint_direction,
  output var  logic        wrap_buffer_enable
);

  cdma_pkg::cdma_top_s r_q;
  cdma_pkg::cdma_top_s r_d;

  cdma_scan_if sif ();

  cdma_slot_scan #(
    .NUM_SLOTS (`CDMA_NUM_SLOTS)
  ) u_scan (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sif     (sif)
  );

  assign sif.go    = r_q.scan_go;
  assign sif.start = r_q.slot;
  assign sif.mask  = r_q.slot_select;

  logic                   enabled;
  logic                   dir_in;
  logic [`CDMA_IDX_W-1:0] idx;
  logic                   req_seen;

  assign enabled  = r_q.ctl[`CDMA_CTL_EN_BIT];
  assign dir_in   = r_q.ctl[`CDMA_CTL_DIR_BIT];
  assign idx      = avs_address[17:2];
  assign req_seen = (avs_read || avs_write) && r_q.waitreq;

  always_comb begin
    r_d         = r_q;
    r_d.scan_go = 1'b0;

    // ==========================================================================
    // Register bus: one wait cycle, answer while waitrequest is low
    if (!r_q.waitreq) begin
      r_d.waitreq = 1'b1;
      if (avs_write && avs_byteenable[0]) begin
        unique case (idx)
          `CDMA_CTL_IDX: r_d.ctl = avs_writedata[7:0] & `CDMA_CTL_WR_MASK;
          `CDMA_SLOT_HI_IDX: begin
            r_d.slot_byte_count   = avs_writedata[`CDMA_SLOT_HI_CNT_MSB:`CDMA_SLOT_HI_CNT_LSB];
            r_d.slot_select[13:8] = avs_writedata[`CDMA_SLOT_HI_SEL_MSB:`CDMA_SLOT_HI_SEL_LSB];
          end
          `CDMA_SLOT_LO_IDX: r_d.slot_select[7:0] = avs_writedata[7:0];
          default: ;
        endcase
      end
    end else if (req_seen) begin
      r_d.waitreq = 1'b0;
      r_d.rdata   = 32'h0000_0000;
      if (avs_read) begin
        unique case (idx)
          `CDMA_CTL_IDX:  r_d.rdata[7:0] = r_q.ctl;
          `CDMA_SLOT_HI_IDX: r_d.rdata[7:0] = {r_q.slot_byte_count, r_q.slot_select[13:8]};
          `CDMA_SLOT_LO_IDX: r_d.rdata[7:0] = r_q.slot_select[7:0];
          `CDMA_STAT_IDX: begin
            r_d.rdata[2:0]   = r_q.state;
            r_d.rdata[7:4]   = r_q.slot;
            r_d.rdata[9:8]   = r_q.byte_idx;
            r_d.rdata[16]    = r_q.overrun;
          end
          default: ;
        endcase
      end
    end
    // Read of status clears the sticky overrun, but a new overrun wins
    if (!r_q.waitreq && avs_read && idx == `CDMA_STAT_IDX) begin
      r_d.overrun = 1'b0;
    end

    // ==========================================================================
    // Slot sequencer
    unique case (r_q.state)
      cdma_pkg::CDMA_IDLE: begin
        if (enabled && cpi_frame_start) begin
          r_d.slot  = 4'h0;
          r_d.state = cdma_pkg::CDMA_SCAN;
        end
      end
      cdma_pkg::CDMA_SCAN: begin
        r_d.scan_go = 1'b1;
        r_d.state   = cdma_pkg::CDMA_SCAN_WAIT;
      end
      cdma_pkg::CDMA_SCAN_WAIT: begin
        if (sif.done) begin
          if (sif.found) begin
            r_d.slot     = sif.index;
            r_d.byte_idx = 2'b00;
            r_d.state    = cdma_pkg::CDMA_SRC;
            r_d.cpi_rd   = dir_in;
            r_d.buf_req  = !dir_in;
            r_d.buf_we   = 1'b0;
          end else begin
            r_d.state = cdma_pkg::CDMA_IDLE;
          end
        end
      end
      cdma_pkg::CDMA_SRC: begin
        if (dir_in && cpi_ack) begin
          r_d.data    = cpi_rdata;
          r_d.cpi_rd  = 1'b0;
          r_d.buf_req = 1'b1;
          r_d.buf_we  = 1'b1;
          r_d.state   = cdma_pkg::CDMA_DST;
        end else if (!dir_in && bufmgr_ack) begin
          r_d.data    = bufmgr_rdata;
          r_d.buf_req = 1'b0;
          r_d.cpi_wr  = 1'b1;
          r_d.state   = cdma_pkg::CDMA_DST;
        end
      end
      cdma_pkg::CDMA_DST: begin
        if ((dir_in && bufmgr_ack) || (!dir_in && cpi_ack)) begin
          r_d.buf_req = 1'b0;
          r_d.buf_we  = 1'b0;
          r_d.cpi_wr  = 1'b0;
          if (r_q.byte_idx != r_q.slot_byte_count) begin
            r_d.byte_idx = r_q.byte_idx + 2'b01;
            r_d.cpi_rd   = dir_in;
            r_d.buf_req  = !dir_in;
            r_d.state    = cdma_pkg::CDMA_SRC;
          end else if (r_q.slot == `CDMA_LAST_SLOT) begin
            r_d.state = cdma_pkg::CDMA_IDLE;
          end else begin
            r_d.slot  = r_q.slot + 4'h1;
            r_d.state = cdma_pkg::CDMA_SCAN;
          end
        end
      end
    endcase

    // Frame start while the last frame is still running is dropped
    if (cpi_frame_start && r_q.state != cdma_pkg::CDMA_IDLE) begin
      r_d.overrun = 1'b1;
    end

    // Clearing enable aborts at once; any open handshake is dropped
    if (!enabled) begin
      r_d.state   = cdma_pkg::CDMA_IDLE;
      r_d.cpi_rd  = 1'b0;
      r_d.cpi_wr  = 1'b0;
      r_d.buf_req = 1'b0;
      r_d.buf_we  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_q         <= '0;
      r_q.ctl     <= `CDMA_CTL_RST;
      r_q.slot_select <= 14'({`CDMA_SLOT_HI_RST, `CDMA_SLOT_LO_RST} & 16'h3fff);
      r_q.waitreq <= 1'b1;
      r_q.state   <= cdma_pkg::CDMA_IDLE;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from r_q
  assign avs_readdata       = r_q.rdata;
  assign avs_waitrequest    = r_q.waitreq;
  assign cpi_rd_req         = r_q.cpi_rd;
  assign cpi_wr_req         = r_q.cpi_wr;
  assign cpi_slot           = r_q.slot;
  assign cpi_byte           = r_q.byte_idx;
  assign cpi_wdata          = r_q.data;
  assign bufmgr_req         = r_q.buf_req;
  assign bufmgr_write       = r_q.buf_we;
  assign bufmgr_wdata       = r_q.data;
  assign endpoint_number    = r_q.ctl[`CDMA_CTL_EP_MSB:`CDMA_CTL_EP_LSB];
  assign endpoint_direction = r_q.ctl[`CDMA_CTL_DIR_BIT];
  assign wrap_buffer_enable = r_q.ctl[`CDMA_CTL_WRAP_BIT];

endmodule // cdma_channel

`default_nettype wire

// ==== cdma_monitor.sv ====
// Port checker for the codec slot DMA channel
`timescale 1ns/1ps
`default_nettype none

module cdma_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [17:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        cpi_rd_req,
  input wire logic        cpi_wr_req,
  input wire logic [3:0]  cpi_slot,
  input wire logic [1:0]  cpi_byte,
  input wire logic        cpi_ack,
  input wire logic        bufmgr_req,
  input wire logic        bufmgr_write,
  input wire logic        bufmgr_ack,
  input wire logic [2:0]  endpoint_number,
  input wire logic        endpoint_direction,
  input wire logic        wrap_buffer_enable
);
  // ====================
  // Register mirrors
  logic      [7:0]  ctl_q;
  logic      [7:0]  sel_hi_q;
  logic      [7:0]  sel_lo_q;
  wire logic [15:0] idx = avs_address[17:2];
  wire logic        wac = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire logic [13:0] sel = {sel_hi_q[5:0], sel_lo_q};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_q    <= 8'h00;
      sel_hi_q <= 8'h00;
      sel_lo_q <= 8'h00;
    end else if (wac) begin
      if (idx == 16'hfff4) ctl_q <= avs_writedata[7:0] & 8'hcf;
      if (idx == 16'hfff5) sel_hi_q <= avs_writedata[7:0];
      if (idx == 16'hfff6) sel_lo_q <= avs_writedata[7:0];
    end
  end
  // ====================
  // Properties
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not low for exactly one cycle");
  chk_ctl_read: assert property (
    avs_read && !avs_waitrequest && idx == 16'hfff4 |-> avs_readdata[7:0] == ctl_q)
    else $error("control readback wrong");
  chk_slot_read: assert property (
    avs_read && !avs_waitrequest && idx == 16'hfff5 |-> avs_readdata[7:0] == sel_hi_q)
    else $error("slot high readback wrong");
  chk_cfg_ports: assert property (
    $stable(ctl_q) |-> {wrap_buffer_enable, endpoint_direction, endpoint_number} == {ctl_q[6], ctl_q[3], ctl_q[2:0]})
    else $error("configuration outputs differ from control");
  chk_idle_off: assert property (
    !ctl_q[7] && $past(!ctl_q[7]) |-> !(cpi_rd_req || cpi_wr_req || bufmgr_req))
    else $error("request while disabled");
  chk_dir_legs: assert property (
    (cpi_rd_req || bufmgr_req && bufmgr_write) |-> ctl_q[3] && !cpi_wr_req)
    else $error("IN leg with OUT direction");
  chk_slot_sel: assert property (
    (cpi_rd_req || cpi_wr_req) |-> sel[cpi_slot] && cpi_byte <= sel_hi_q[7:6])
    else $error("unselected slot or byte beyond count");
  chk_req_hold: assert property (
    cpi_rd_req && !cpi_ack && ctl_q[7] |=> cpi_rd_req && $stable(cpi_slot) && $stable(cpi_byte))
    else $error("codec request dropped before answer");
  chk_out_order: assert property (
    bufmgr_ack && bufmgr_req && !bufmgr_write |-> ##[1:2] cpi_wr_req)
    else $error("codec write did not follow buffer read");
endmodule // cdma_monitor

bind cdma_channel cdma_monitor cdma_monitor_i (.*);

`default_nettype wire

// ==== cdma_far_model.sv ====
// Codec port and USB buffer manager model facing the channel
`timescale 1ns/1ps
`default_nettype none

module cdma_far_model (
  input  wire logic       clk,
  input  wire logic [1:0] lat,
  input  wire logic       cpi_rd_req,
  input  wire logic       cpi_wr_req,
  input  wire logic [3:0] cpi_slot,
  input  wire logic [1:0] cpi_byte,
  input  wire logic [7:0] cpi_wdata,
  output var  logic [7:0] cpi_rdata,
  output var  logic       cpi_ack,
  input  wire logic       bufmgr_req,
  input  wire logic       bufmgr_write,
  input  wire logic [7:0] bufmgr_wdata,
  output var  logic [7:0] bufmgr_rdata,
  output var  logic       bufmgr_ack
);
  logic      [1:0] cn_q = 2'h0;
  logic      [1:0] un_q = 2'h0;
  logic            ca_q = 1'b0;
  logic            ua_q = 1'b0;
  logic      [7:0] seq_q = 8'h00;
  logic      [7:0] got[$];
  wire logic [7:0] cb = {cpi_slot, 2'h0, cpi_byte};
  wire logic       cr = cpi_rd_req || cpi_wr_req;
  // One-pulse answers lat+1 cycles after the request appears, only to an open request
  always @(posedge clk) begin
    ca_q <= cr && !ca_q && cn_q == lat;
    cn_q <= (cr && !ca_q && cn_q != lat) ? cn_q + 2'h1 : 2'h0;
    ua_q <= bufmgr_req && !ua_q && un_q == lat;
    un_q <= (bufmgr_req && !ua_q && un_q != lat) ? un_q + 2'h1 : 2'h0;
    if (ua_q && bufmgr_write) got.push_back(bufmgr_wdata);
    if (ua_q && !bufmgr_write) seq_q <= seq_q + 8'h01;
    if (ca_q && cpi_wr_req) got.push_back(cpi_wdata);
  end
  assign cpi_ack = ca_q;
  assign bufmgr_ack = ua_q;
  // Inverted off the answer so a stale sample never passes
  assign cpi_rdata = ca_q ? cb : ~cb;
  assign bufmgr_rdata = ua_q ? seq_q : ~seq_q;
endmodule // cdma_far_model

`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the codec slot DMA channel
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [17:0] avs_address = 18'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic        cpi_frame_start = 1'b0;
  logic [1:0]  lat = 2'h0;
  logic [31:0] q;
  int          failures = 0;
  int          checks = 0;
  wire logic [31:0] avs_readdata;
  wire logic        avs_waitrequest, cpi_rd_req, cpi_wr_req, cpi_ack, bufmgr_req, bufmgr_write, bufmgr_ack;
  wire logic [3:0]  cpi_slot;
  wire logic [1:0]  cpi_byte;
  wire logic [7:0]  cpi_wdata, cpi_rdata, bufmgr_wdata, bufmgr_rdata;
  wire logic [2:0]  endpoint_number;
  wire logic        endpoint_direction, wrap_buffer_enable;

  cdma_channel   cdma_channel_i (.*);
  cdma_far_model far_i (.*);

  always #2 clk = ~clk;

  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic hang();
    failures++;
    conclude();
  endtask

  // ====================
  // Avalon access, one idle cycle after each
  task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d, input logic [3:0] b);
    int n;
    n = 0;
    avs_address <= {i, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= b;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 50) hang();
      @(posedge clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pulse();
    cpi_frame_start <= 1'b1;
    @(posedge clk);
    cpi_frame_start <= 1'b0;
  endtask

  // One frame over the selected slots, then a frame while disabled
  task automatic run(input logic in, input logic [13:0] m, input logic [1:0] b);
    logic [7:0] e[$];
    int         n;
    far_i.got.delete();
    for (int s = 0; s < 14; s++)
      if (m[s])
        for (int k = 0; k <= b; k++)
          e.push_back(in ? {s[3:0], 2'h0, k[1:0]} : far_i.seq_q + 8'(e.size()));
    bus(1'b1, 16'hfff6, m[7:0], 4'h1);
    bus(1'b1, 16'hfff5, {b, m[13:8]}, 4'h1);
    bus(1'b1, 16'hfff4, {4'h0, in, 3'h1}, 4'h1);
    bus(1'b1, 16'hfff4, {4'h8, in, 3'h1}, 4'h1);
    pulse();
    // Second start while busy must be dropped and flagged as overrun
    repeat (2) @(posedge clk);
    pulse();
    n = 0;
    while (far_i.got.size() < e.size()) begin
      n++;
      if (n > 900) hang();
      @(posedge clk);
    end
    // Room for any stray extra byte to show
    repeat (4) @(posedge clk);
    chk(far_i.got.size(), e.size());
    foreach (e[j]) chk(far_i.got[j], e[j]);
    // Status: idle, last slot 13, last byte index, overrun then cleared by the read
    bus(1'b0, 16'hfff0, 8'h00, 4'h0);
    chk(q, 32'h0001_00d0 | (32'(b) << 8));
    bus(1'b0, 16'hfff0, 8'h00, 4'h0);
    chk(q, 32'h0000_00d0 | (32'(b) << 8));
    bus(1'b1, 16'hfff4, {4'h0, in, 3'h1}, 4'h1);
    pulse();
    repeat (20) @(posedge clk);
    chk(far_i.got.size(), e.size());
  endtask

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 4; i < 7; i++) begin
      bus(1'b0, 16'hfff0 + 16'(i), 8'h00, 4'h0);
      chk(q, 32'h0);
    end
    bus(1'b1, 16'hfff4, 8'h7f, 4'h1);
    bus(1'b1, 16'hfff4, 8'h00, 4'h0);
    bus(1'b0, 16'hfff4, 8'h00, 4'h0);
    chk(q, 32'h4f);
    chk({wrap_buffer_enable, endpoint_direction, endpoint_number}, 32'h1f);
    bus(1'b1, 16'h0010, 8'hff, 4'h1);
    bus(1'b0, 16'h0010, 8'h00, 4'h0);
    chk(q, 32'h0);
    bus(1'b1, 16'hfff5, 8'hff, 4'h1);
    bus(1'b0, 16'hfff5, 8'h00, 4'h0);
    chk(q, 32'hff);
    for (int b = 0; b < 4; b++) begin
      lat <= 2'(b);
      run(b[0], 14'h2025, 2'(b));
    end
    conclude();
  end
endmodule // tb_top

`default_nettype wire
